// File: src/bcd_pkg.sv
// Shared constants for the bus clock delay tuning block
package bcd_pkg;
  // Register offsets (byte addresses)
  localparam logic [7:0]  DELAY_CTRL_OFS   = 8'h00;
  localparam logic [7:0]  DELAY_STAT_OFS   = 8'h04;
  localparam logic [7:0]  BUS_RESET_OFS    = 8'h08;
  // Field positions
  localparam int          SLOT_DEL_LSB     = 28;
  localparam int          PLL_DEL_LSB      = 24;
  localparam int          SETTLE_BIT       = 0;
  localparam int          BUS_RESET_BIT    = 0;
  // Widths and reset values
  localparam int          DEL_W            = 4;
  localparam int          TAP_IDX_W        = 5;
  localparam int          HIST_W           = 32;
  localparam int          SLOT_CLK_N       = 5;
  localparam logic [3:0]  SLOT_DEL_RST     = 4'h0;
  localparam logic [3:0]  PLL_DEL_RST      = 4'h0;
  localparam logic        BUS_RESET_RST    = 1'b1;
  // Lock loss window after a PLL delay step
  localparam int          CLK_PERIOD_NS    = 100;
  localparam int          LOCK_LOSS_US     = 100;
  localparam int          LOCK_LOSS_CYC    =
    (LOCK_LOSS_US * 1000) / CLK_PERIOD_NS;
  localparam int          SETTLE_W         = 10;
  // Stepper states
  typedef enum logic [1:0] {
    BCD_IDLE = 2'b01,
    BCD_WAIT = 2'b10
  } bcd_step_e;
endpackage

// File: src/bcd_pll_stepper.sv
// Glitch-free one-tap-at-a-time mover for the PLL output delay
`timescale 1ns/1ps
module bcd_pll_stepper (
  // Clock, reset, enable
  input  wire logic  sys_clk_in,
  input  wire logic  resetn_in,
  input  wire logic  ce_in,
  // Tap link to the core
  bcd_tap_if.stepper tap
);
  import bcd_pkg::*;

  bcd_step_e        state;
  logic [DEL_W-1:0] nbr;
  logic             safe;

  // Neighbour tap one step toward the target
  always_comb begin
    nbr  = (tap.target > tap.applied) ? tap.applied + 4'h1
                                      : tap.applied - 4'h1;
    safe = tap.hist[tap.applied] == tap.hist[nbr];
  end

  // Move only while both taps agree, so no edge is cut short
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tap.applied <= PLL_DEL_RST;
      tap.step    <= 1'b0;
      state       <= BCD_IDLE;
    end else if (ce_in) begin
      tap.step <= 1'b0;
      case (state)
        BCD_IDLE: begin
          if (tap.target != tap.applied) begin
            state <= BCD_WAIT;
          end
        end
        BCD_WAIT: begin
          if (tap.target == tap.applied) begin
            state <= BCD_IDLE;
          end else if (safe) begin
            tap.applied <= nbr;
            tap.step    <= 1'b1;
            state       <= BCD_IDLE;
          end
        end
        default: state <= BCD_IDLE;
      endcase
    end
  end

  AST_PLL_NO_GLITCH: assert property (
    @(posedge sys_clk_in) disable iff (!resetn_in || !ce_in)
    (tap.applied != $past(tap.applied)) |-> $past(safe))
    else $error("PLL tap moved across an edge");

  AST_PLL_ONE_STEP: assert property (
    @(posedge sys_clk_in) disable iff (!resetn_in || !ce_in)
    $past(ce_in) && tap.step |->
      (tap.applied == $past(tap.applied) + 4'h1) ||
      (tap.applied == $past(tap.applied) - 4'h1))
    else $error("PLL tap moved by more than one");
endmodule

// File: src/bcd_tap_if.sv
// Signals shared between the delay core and the PLL tap stepper
`timescale 1ns/1ps
interface bcd_tap_if;
  import bcd_pkg::*;
  logic [HIST_W-1:0] hist;
  logic [DEL_W-1:0]  target;
  logic [DEL_W-1:0]  applied;
  logic              step;
  modport core    (output hist, output target,
                   input applied, input step);
  modport stepper (input hist, input target,
                   output applied, output step);
endinterface

// File: src/bcd_top.sv
// Bus clock delay tuning: tap delay for slot clocks and PLL reference
// Operation
// - Slot clocks lag the PLL reference by slot field times one tap.
// - Rewriting the slot field may glitch slot clocks; no protection given.
// - PLL reference output is delayed by the PLL field times one tap.
// - Rewriting the PLL field shifts its delay with no output glitch.
// - A PLL field change may cost PLL lock until 100 us after its last tap step.
`timescale 1ns/1ps
module bcd_top
  import bcd_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                        sys_clk_in,
  input  wire logic                        resetn_in,
  input  wire logic                        ce_in,
  // Undelayed clock source, same clock domain
  input  wire logic                        src_clk_in,
  // Register port
  input  wire logic [7:0]                  addr_in,
  input  wire logic [31:0]                 wdata_in,
  input  wire logic                        wr_in,
  input  wire logic                        rd_in,
  output logic      [31:0]                 rdata_out,
  // Delayed clocks and bus control
  output logic                             pll_reference_clock_out,
  output logic      [bcd_pkg::SLOT_CLK_N-1:0] slot_clock_out,
  output logic                             secondary_bus_reset_out,
  output logic                             pll_settling_out
);
  import bcd_pkg::*;

  bcd_tap_if tap ();

  logic [DEL_W-1:0]     slot_clock_delay_field;
  logic [DEL_W-1:0]     pll_out_delay_field;
  logic                 secondary_bus_reset_bit;
  logic [SETTLE_W-1:0]  settle_cnt;
  logic [HIST_W-1:0]    hist;
  logic [TAP_IDX_W-1:0] slot_idx;
  logic                 ctrl_wr;

  // Lock-loss span as a plain int, so it can bound a delay range
  localparam int        SETTLE_SPAN = LOCK_LOSS_CYC;

  assign tap.hist   = hist;
  assign tap.target = pll_out_delay_field;
  assign ctrl_wr    = wr_in && (addr_in == DELAY_CTRL_OFS);

  bcd_pll_stepper u_stepper (
    .sys_clk_in (sys_clk_in),
    .resetn_in  (resetn_in),
    .ce_in      (ce_in),
    .tap        (tap)
  );

  // Delay line, one flop per tap
  // One tap is one clock period; finer steps would need a real delay chain
  // A source slower than two taps per level keeps PLL steps possible
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      hist <= 32'h0000_0000;
    end else if (ce_in) begin
      hist <= {hist[HIST_W-2:0], src_clk_in};
    end
  end

  // Slot taps sit behind the PLL tap so their lag is measured from it
  always_comb begin
    slot_idx = {1'b0, tap.applied} + {1'b0, slot_clock_delay_field};
  end

  // Registered clock outputs
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pll_reference_clock_out <= 1'b0;
      slot_clock_out          <= 5'h00;
    end else if (ce_in) begin
      pll_reference_clock_out <= hist[tap.applied];
      slot_clock_out          <= {SLOT_CLK_N{hist[slot_idx]}};
    end
  end

  // Control fields; slot field applies at once, so it may glitch
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      slot_clock_delay_field  <= SLOT_DEL_RST;
      pll_out_delay_field     <= PLL_DEL_RST;
      secondary_bus_reset_bit <= BUS_RESET_RST;
    end else if (ce_in) begin
      if (ctrl_wr) begin
        slot_clock_delay_field <= wdata_in[SLOT_DEL_LSB +: DEL_W];
        pll_out_delay_field    <= wdata_in[PLL_DEL_LSB +: DEL_W];
      end
      if (wr_in && (addr_in == BUS_RESET_OFS)) begin
        secondary_bus_reset_bit <= wdata_in[BUS_RESET_BIT];
      end
    end
  end

  // Bus reset pin follows its control bit
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      secondary_bus_reset_out <= BUS_RESET_RST;
    end else if (ce_in) begin
      secondary_bus_reset_out <= secondary_bus_reset_bit;
    end
  end

  // Lock-loss window, restarted on every tap step
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      settle_cnt       <= 10'h000;
      pll_settling_out <= 1'b0;
    end else if (ce_in) begin
      if (tap.step) begin
        settle_cnt       <= SETTLE_W'(LOCK_LOSS_CYC - 1);
        pll_settling_out <= 1'b1;
      end else if (settle_cnt != 10'h000) begin
        settle_cnt <= settle_cnt - 10'h001;
      end else begin
        pll_settling_out <= 1'b0;
      end
    end
  end

  // Read port; reserved and unmapped bits read as zero
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_out <= 32'h0000_0000;
    end else if (ce_in) begin
      rdata_out <= 32'h0000_0000;
      if (rd_in) begin
        case (addr_in)
          DELAY_CTRL_OFS: begin
            rdata_out[SLOT_DEL_LSB +: DEL_W] <= slot_clock_delay_field;
            rdata_out[PLL_DEL_LSB +: DEL_W]  <= pll_out_delay_field;
          end
          DELAY_STAT_OFS: begin
            rdata_out[PLL_DEL_LSB +: DEL_W] <= tap.applied;
            rdata_out[SETTLE_BIT]           <= pll_settling_out;
          end
          BUS_RESET_OFS: rdata_out[BUS_RESET_BIT] <= secondary_bus_reset_bit;
          default: rdata_out <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Register port checks
  // Control reads show both fields and nothing below them
  sequence s_ctrl_read;
    rd_in && (addr_in == DELAY_CTRL_OFS);
  endsequence

  sequence s_stat_read;
    rd_in && (addr_in == DELAY_STAT_OFS);
  endsequence

  // Status shows the tap in use and the lock-loss flag
  AST_STAT_READ: assert property (
    @(posedge sys_clk_in) disable iff (!resetn_in || !ce_in)
    s_stat_read |=>
      rdata_out[PLL_DEL_LSB +: DEL_W] == $past(tap.applied) &&
      rdata_out[SETTLE_BIT] == $past(pll_settling_out))
    else $error("Status read does not match state");

  AST_STAT_RSVD: assert property (
    @(posedge sys_clk_in) disable iff (!resetn_in || !ce_in)
    s_stat_read |=> rdata_out[23:1] == 23'h000000)
    else $error("Reserved status bits not zero");

  AST_CTRL_READBACK: assert property (
    @(posedge sys_clk_in) disable iff (!resetn_in || !ce_in)
    s_ctrl_read |=>
      rdata_out[SLOT_DEL_LSB +: DEL_W] == $past(slot_clock_delay_field) &&
      rdata_out[PLL_DEL_LSB +: DEL_W] == $past(pll_out_delay_field))
    else $error("Control read does not match fields");

  // Read data stands one cycle only, then falls back to zero
  AST_RDATA_IDLE: assert property (
    @(posedge sys_clk_in) disable iff (!resetn_in || !ce_in)
    ce_in && !rd_in |=> rdata_out == 32'h0000_0000)
    else $error("Read data not cleared after read");

  AST_RSVD_ZERO: assert property (
    @(posedge sys_clk_in) disable iff (!resetn_in || !ce_in)
    s_ctrl_read |=> rdata_out[23:0] == 24'h000000)
    else $error("Reserved control bits not zero");

  AST_SLOT_WRITE: assert property (
    @(posedge sys_clk_in) disable iff (!resetn_in || !ce_in)
    ce_in && ctrl_wr |=>
      slot_clock_delay_field == $past(wdata_in[SLOT_DEL_LSB +: DEL_W]))
    else $error("Slot delay not applied on write");

  // Tap outputs follow the history one enabled edge later
  AST_SLOT_TAP: assert property (
    @(posedge sys_clk_in) disable iff (!resetn_in || !ce_in)
    ce_in |=> slot_clock_out ==
      {SLOT_CLK_N{$past(hist[slot_idx])}})
    else $error("Slot clock not at slot tap");

  AST_PLL_TAP: assert property (
    @(posedge sys_clk_in) disable iff (!resetn_in || !ce_in)
    ce_in |=> pll_reference_clock_out == $past(hist[tap.applied]))
    else $error("PLL reference not at its tap");

  // Lock-loss window checks; a later step restarts the window
  sequence s_step;
    ce_in && tap.step;
  endsequence

  AST_SETTLE_START: assert property (
    @(posedge sys_clk_in) disable iff (!resetn_in || !ce_in)
    s_step |=> pll_settling_out &&
      settle_cnt == SETTLE_W'(LOCK_LOSS_CYC - 1))
    else $error("Settle window not started");

  AST_SETTLE_BOUND: assert property (
    @(posedge sys_clk_in) disable iff (!resetn_in || !ce_in)
    s_step |=> ##[0:SETTLE_SPAN] (!pll_settling_out || tap.step))
    else $error("Settle window exceeds 100 us");
endmodule

// File: testbench/bcd_src_model.sv
// Upstream clock source that feeds the delay line
`timescale 1ns/1ps
module bcd_src_model #(
  parameter int HALF = 4
) (
  // Clock and reset
  input  wire logic sys_clk_in,
  input  wire logic resetn_in,
  // Undelayed clock towards the block
  output logic      src_clk_out
);
  int cnt;
  // Square wave; a slow one so that neighbouring taps often agree
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt         <= 0;
      src_clk_out <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt         <= 0;
      src_clk_out <= !src_clk_out;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// File: testbench/bcd_top_tb.sv
// Self-checking bench for the bus clock delay tuning block
`timescale 1ns/1ps
module bcd_top_tb;
  import bcd_pkg::*;
  logic                  sys_clk_in = 1'b0;
  logic                  resetn_in  = 1'b0;
  logic                  ce         = 1'b1;
  logic                  src_clk;
  logic [7:0]            addr       = 8'h00;
  logic [31:0]           wdata      = 32'h0;
  logic                  wr         = 1'b0;
  logic                  rd         = 1'b0;
  logic [31:0]           rdata;
  logic                  pll_out;
  logic [SLOT_CLK_N-1:0] slot_out;
  logic                  bus_rst;
  logic                  settling;
  logic [63:0]           sh         = 64'h0;
  logic [3:0]            po         = 4'h0;
  bit                    watch      = 1'b0;
  int                    n_mismatch = 0;
  int                    n_checks   = 0;

  // 100 ns clock
  always #50 sys_clk_in = ~sys_clk_in;

  // Source history; sh[k] is the value taken k edges ago
  always @(posedge sys_clk_in) sh <= {sh[62:0], src_clk};

  bcd_src_model SRC (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
                     .src_clk_out(src_clk));

  bcd_top DUT (
    .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .ce_in(ce),
    .src_clk_in(src_clk), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
    .rd_in(rd), .rdata_out(rdata), .pll_reference_clock_out(pll_out),
    .slot_clock_out(slot_out), .secondary_bus_reset_out(bus_rst),
    .pll_settling_out(settling));

  task automatic chk(input string what, input logic [31:0] exp, act);
    n_checks++;
    if (act !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, act);
    end
  endtask

  // A PLL output edge must follow a full half period of one level
  always @(negedge sys_clk_in) begin
    if (watch && pll_out !== po[0])
      chk("pll run", {28'h0, {4{po[0]}}}, {28'h0, po});
    po <= {po[2:0], pll_out};
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge sys_clk_in);
    wr <= 1'b0;
  endtask

  // Read data is looked at only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk_in);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk_in);
    rd <= 1'b0;
    @(negedge sys_clk_in);
    d = rdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd_reg(a, d);
    chk("register read", e, d);
    @(negedge sys_clk_in);
    chk("read data idle", 32'h0, rdata);
  endtask

  // Compare both outputs against the source history for n cycles
  task automatic taps(input int a, input int s, input int n);
    repeat (3) @(negedge sys_clk_in);
    repeat (n) begin
      @(negedge sys_clk_in);
      chk("pll clock", {31'h0, sh[1 + a]}, {31'h0, pll_out});
      chk("slot clocks", {27'h0, {5{sh[1 + a + s]}}},
          {27'h0, slot_out});
    end
  endtask

  task automatic step_pll(input logic [3:0] t);
    logic [31:0] d;
    int          n;
    wr_reg(DELAY_CTRL_OFS, {4'h0, t, 24'h0});
    for (n = 0; n < 300 && settling !== 1'b1; n++) @(negedge sys_clk_in);
    for (n = 0; n < 2000 && settling === 1'b1; n++) @(negedge sys_clk_in);
    chk("settle cycles", LOCK_LOSS_CYC, 32'(n));
    rd_reg(DELAY_STAT_OFS, d);
    chk("applied tap", {28'h0, t}, {28'h0, d[27:24]});
  endtask

  task automatic t_reset();
    chk("bus reset out", 32'h1, {31'h0, bus_rst});
    chk("settling out", 32'h0, {31'h0, settling});
    rd_chk(DELAY_CTRL_OFS, 32'h0);
    rd_chk(BUS_RESET_OFS, 32'h1);
    rd_chk(DELAY_STAT_OFS, 32'h0);
    rd_chk(8'h0C, 32'h0);
    $display("t_reset done");
  endtask

  task automatic t_pll();
    watch = 1'b1;
    for (int t = 1; t <= 3; t++) step_pll(4'(t));
    taps(3, 0, 40);
    $display("t_pll done");
  endtask

  // Slot field swept under bus reset; reserved bits written as ones
  task automatic t_slot();
    wr_reg(BUS_RESET_OFS, 32'h1);
    for (int s = 0; s < 16; s++) begin
      wr_reg(DELAY_CTRL_OFS, {4'(s), 4'h3, 24'hFFFFFF});
      rd_chk(DELAY_CTRL_OFS, {4'(s), 4'h3, 24'h0});
      taps(3, s, 24);
    end
    repeat (10000) @(posedge sys_clk_in);
    wr_reg(BUS_RESET_OFS, 32'h0);
    // Bit lands on the write edge, the pin one edge later
    repeat (2) @(negedge sys_clk_in);
    chk("bus reset out", 32'h0, {31'h0, bus_rst});
    rd_chk(BUS_RESET_OFS, 32'h0);
    $display("t_slot done");
  endtask

  // Clock enable low: outputs hold and a write is ignored
  task automatic t_ce();
    logic                  p;
    logic [SLOT_CLK_N-1:0] s;
    watch = 1'b0;
    @(posedge sys_clk_in);
    ce <= 1'b0;
    @(negedge sys_clk_in);
    p = pll_out;
    s = slot_out;
    wr_reg(DELAY_CTRL_OFS, 32'h5000_0000);
    repeat (8) begin
      @(negedge sys_clk_in);
      chk("frozen pll clock", {31'h0, p}, {31'h0, pll_out});
      chk("frozen slot clocks", {27'h0, s}, {27'h0, slot_out});
    end
    @(posedge sys_clk_in);
    ce <= 1'b1;
    rd_chk(DELAY_CTRL_OFS, 32'hF300_0000);
    $display("t_ce done");
  endtask

  // Reset in mid-run brings every field back to its reset value
  task automatic t_rst2();
    @(posedge sys_clk_in);
    resetn_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    @(negedge sys_clk_in);
    t_reset();
    $display("t_rst2 done");
  endtask

  initial begin
    repeat (6) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    @(negedge sys_clk_in);
    t_reset();
    t_pll();
    t_slot();
    t_ce();
    t_rst2();
    end_sim();
  end
endmodule
